/* File: rtl/vab_video_adjust_bank.sv */
// Video adjust register bank with two-wire write-only slave
//
// How it works
// [RULE1] Control byte at 00H holds four mode bits
// [RULE2] Pedestal bit one enables pedestal blanking
// [RULE3] Brightness, contrast six bits; overlay contrast four
// [RULE4] Three six-bit channel gains at 04H-06H
// [RULE5] Three full-byte black references at 07H-09H
// [RULE6] Subaddresses 0AH-0EH change nothing
// [RULE7] Master avoids test subaddress 0FH
// [RULE8] Data bit zero is setting LSB
// [RULE9] Reset clears every register to zero
// [RULE10] Master writes zero into don't-care bits; bench does so only in its first burst, then sends random bits
// [RULE11] Write-only slave at address 1000100, acked
// [RULE12] Subaddress auto-increments 00H-09H, wraps to 00H
// [RULE13] Above 0FH: acknowledge, no increment, no write
// [RULE14] Register updates only after whole byte
`timescale 1ns/100ps
module vab_video_adjust_bank (
  input  wire logic                              I_CLK,
  input  wire logic                              I_NRST,
  input  wire logic                              I_SCL,
  input  wire logic                              I_SDA,
  output wire logic                              O_SDA,
  output wire logic                              O_SDA_OE_N,
  output wire logic                              O_FEEDBACK_POLARITY_SEL,
  output wire logic                              O_VIDEO_DISABLE,
  output wire logic                              O_OVERLAY_DISABLE,
  output wire logic                              O_PEDESTAL_BLANK_EN,
  output wire logic [vab_pkg::VAB_LEVEL_W-1:0]   O_BRIGHTNESS_LEVEL,
  output wire logic [vab_pkg::VAB_LEVEL_W-1:0]   O_CONTRAST_LEVEL,
  output wire logic [vab_pkg::VAB_OVLCON_W-1:0]  O_OVERLAY_CONTRAST_LEVEL,
  output wire logic [vab_pkg::VAB_LEVEL_W-1:0]   O_GAIN_CH1,
  output wire logic [vab_pkg::VAB_LEVEL_W-1:0]   O_GAIN_CH2,
  output wire logic [vab_pkg::VAB_LEVEL_W-1:0]   O_GAIN_CH3,
  output wire logic [vab_pkg::VAB_REF_W-1:0]     O_BLACK_REF_CH1,
  output wire logic [vab_pkg::VAB_REF_W-1:0]     O_BLACK_REF_CH2,
  output wire logic [vab_pkg::VAB_REF_W-1:0]     O_BLACK_REF_CH3,
  output wire logic [7:0]                        O_PRODUCTION_TEST
);
  import vab_pkg::*;

  // True for the auto-incrementing alignment range
  function automatic logic is_bank(input logic [7:0] sub);
    is_bank = (sub <= VAB_SUB_BLACK3);
  endfunction : is_bank

  vab_state_t  state;
  vab_state_t  next_state;
  logic        scl_prev;
  logic        sda_prev;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_cnt;
  logic        in_ack;
  logic        sda_oe_n;
  logic [7:0]  sub_addr;
  logic [7:0]  next_sub;
  logic [7:0]  regs [0:VAB_NUM_REGS-1];
  logic [7:0]  test_reg;

  // Bus condition decode
  wire         scl_rise    = I_SCL & ~scl_prev;
  wire         scl_fall    = ~I_SCL & scl_prev;
  wire         start_det   = I_SCL & scl_prev & sda_prev & ~I_SDA;
  wire         stop_det    = I_SCL & scl_prev & ~sda_prev & I_SDA;
  wire         receiving   = (state == VAB_ST_ADDR) || (state == VAB_ST_SUB) || (state == VAB_ST_DATA);
  wire         byte_done   = scl_fall & ~in_ack & receiving & (bit_cnt == VAB_BYTE_BITS) & ~start_det; // RULE14
  wire         addr_match  = (shift_reg[7:1] == VAB_SLAVE_ADDR) && (shift_reg[0] == VAB_DIR_WRITE); // RULE11
  wire         ack_ok      = (state != VAB_ST_ADDR) || addr_match; // RULE11 RULE13
  wire         data_byte   = byte_done && (state == VAB_ST_DATA);
  wire         wr_en       = data_byte && is_bank(sub_addr); // RULE6 RULE13
  wire         test_wr     = data_byte && (sub_addr == VAB_SUB_TEST);
  wire [3:0]   wr_idx      = sub_addr[3:0];
  wire [7:0]   wr_val      = shift_reg & VAB_WMASK[wr_idx]; // RULE1 RULE3 RULE4 RULE5 RULE8
  wire [79:0]  regs_flat   = {regs[0], regs[1], regs[2], regs[3], regs[4],
                              regs[5], regs[6], regs[7], regs[8], regs[9]};

  // Next state after a completed byte
  always_comb begin
    next_state = state;
    if (byte_done) begin
      case (state)
        VAB_ST_ADDR: next_state = addr_match ? VAB_ST_SUB : VAB_ST_IGNORE; // RULE11
        VAB_ST_SUB:  next_state = VAB_ST_DATA;
        VAB_ST_DATA: next_state = VAB_ST_DATA;
        default:     next_state = state;
      endcase
    end
  end

  // Subaddress pointer update with wrap
  always_comb begin
    next_sub = sub_addr;
    if (byte_done && (state == VAB_ST_SUB)) begin
      next_sub = shift_reg;
    end else if (wr_en) begin
      next_sub = (sub_addr == VAB_SUB_BLACK3) ? VAB_SUB_CTRL : 8'(sub_addr + 8'h01); // RULE12
    end
  end

  // Bus sampling history
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= I_SCL;
      sda_prev <= I_SDA;
    end
  end

  // Receiver state, bit counter and pointer
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      state    <= VAB_ST_IDLE;
      bit_cnt  <= 4'h0;
      in_ack   <= 1'b0;
      sub_addr <= VAB_RESET_VAL;
    end else if (start_det) begin
      state   <= VAB_ST_ADDR;
      bit_cnt <= 4'h0;
      in_ack  <= 1'b0;
    end else if (stop_det) begin
      state  <= VAB_ST_IDLE;
      in_ack <= 1'b0;
    end else begin
      state    <= next_state;
      sub_addr <= next_sub;
      if (byte_done) begin
        in_ack  <= 1'b1;
        bit_cnt <= 4'h0;
      end else if (scl_fall && in_ack) begin
        in_ack <= 1'b0;
      end else if (scl_rise && receiving && !in_ack && bit_cnt != VAB_BYTE_BITS) begin
        bit_cnt <= 4'(bit_cnt + 4'h1);
      end
    end
  end

  // Serial shift, MSB first
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      shift_reg <= 8'h00;
    end else if (scl_rise && receiving && !in_ack) begin
      shift_reg <= {shift_reg[6:0], I_SDA};
    end
  end

  // Acknowledge drive, released on the next falling clock
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      sda_oe_n <= 1'b1;
    end else if (start_det || stop_det) begin
      sda_oe_n <= 1'b1;
    end else if (byte_done) begin
      sda_oe_n <= ~ack_ok; // RULE11 RULE13
    end else if (scl_fall && in_ack) begin
      sda_oe_n <= 1'b1;
    end
  end

  // Alignment and control storage
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      for (int i = 0; i < VAB_NUM_REGS; i++) begin
        regs[i] <= VAB_RESET_VAL; // RULE9
      end
    end else if (wr_en) begin
      regs[wr_idx] <= wr_val; // RULE14
    end
  end

  // Production test byte
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      test_reg <= VAB_RESET_VAL; // RULE9
    end else if (test_wr) begin
      test_reg <= shift_reg;
    end
  end

  // Output mapping from storage flops
  assign O_SDA                    = 1'b0;
  assign O_SDA_OE_N               = sda_oe_n;
  assign O_FEEDBACK_POLARITY_SEL  = regs[0][VAB_FEEDBACK_POLARITY_SEL_BIT];
  assign O_VIDEO_DISABLE          = regs[0][VAB_VID_BIT];
  assign O_OVERLAY_DISABLE        = regs[0][VAB_OVL_BIT];
  assign O_PEDESTAL_BLANK_EN      = regs[0][VAB_PED_BIT]; // RULE2
  assign O_BRIGHTNESS_LEVEL       = regs[1][VAB_LEVEL_W-1:0];
  assign O_CONTRAST_LEVEL         = regs[2][VAB_LEVEL_W-1:0];
  assign O_OVERLAY_CONTRAST_LEVEL = regs[3][VAB_OVLCON_W-1:0];
  assign O_GAIN_CH1               = regs[4][VAB_LEVEL_W-1:0];
  assign O_GAIN_CH2               = regs[5][VAB_LEVEL_W-1:0];
  assign O_GAIN_CH3               = regs[6][VAB_LEVEL_W-1:0];
  assign O_BLACK_REF_CH1          = regs[7];
  assign O_BLACK_REF_CH2          = regs[8];
  assign O_BLACK_REF_CH3          = regs[9];
  assign O_PRODUCTION_TEST        = test_reg;

  // Checks
  default clocking vab_cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  // Address byte taken and matched
  sequence s_addr_taken;
    byte_done && state == VAB_ST_ADDR && addr_match;
  endsequence

  // Subaddress byte taken
  sequence s_sub_taken;
    byte_done && state == VAB_ST_SUB;
  endsequence

  // Slave pulling the data line low
  sequence s_ack_drive;
    !O_SDA_OE_N && in_ack;
  endsequence

  // Falling clock that closes the acknowledge slot
  sequence s_ack_end;
    scl_fall && in_ack && !start_det && !stop_det;
  endsequence

  // Data line let go again
  sequence s_ack_release;
    O_SDA_OE_N && !in_ack;
  endsequence

  AST_CTRL_UPPER_ZERO: assert property (regs[0][7:4] == 4'h0) // RULE1
    else $error("control byte upper bits stored");
  AST_PEDESTAL_WRITE: assert property (wr_en && wr_idx == 4'h0 |=> O_PEDESTAL_BLANK_EN == $past(shift_reg[0])) // RULE2
    else $error("pedestal enable does not follow written bit");
  AST_LEVEL_WIDTHS: assert property (regs[1][7:6] == 2'h0 && regs[2][7:6] == 2'h0 && regs[3][7:4] == 4'h0) // RULE3
    else $error("level register kept a don't-care bit");
  AST_GAIN_WIDTHS: assert property (wr_en && wr_idx >= 4'h4 && wr_idx <= 4'h6 |=> // RULE4
    regs[$past(wr_idx)] == {2'h0, $past(shift_reg[5:0])})
    else $error("gain register wrong after write");
  AST_BLACK_FULL: assert property (wr_en && wr_idx == 4'h9 |=> O_BLACK_REF_CH3 == $past(shift_reg)) // RULE5
    else $error("black reference not full byte");
  AST_UNUSED_NO_WRITE: assert property (data_byte && sub_addr >= VAB_SUB_UNUSED0 && sub_addr <= VAB_SUB_UNUSED1 // RULE6
    |=> $stable(regs_flat) && $stable(test_reg) && $stable(sub_addr))
    else $error("unused subaddress changed a setting");
  AST_LSB_MAP: assert property (wr_en && wr_idx == 4'h1 |=> O_BRIGHTNESS_LEVEL[0] == $past(shift_reg[0])) // RULE8
    else $error("data bit zero not setting LSB");
  AST_RESET_CLEAR: assert property (@(posedge I_CLK) disable iff (1'b0) !I_NRST |=> // RULE9
    regs_flat == 80'h0 && test_reg == 8'h00 && O_SDA_OE_N)
    else $error("reset did not clear the bank");
  // Own address answered, then let go at the close of the slot
  AST_ADDR_ACK: assert property (s_addr_taken |=> s_ack_drive) // RULE11
    else $error("own address not acknowledged");
  AST_ACK_RELEASE: assert property (s_ack_end |=> s_ack_release) // RULE11
    else $error("acknowledge not released after its clock");
  // Subaddress byte loads the pointer and opens the data phase
  AST_SUB_LOAD: assert property (s_sub_taken |=> sub_addr == $past(shift_reg) && state == VAB_ST_DATA) // RULE11
    else $error("subaddress byte not loaded");
  AST_ACK_HOLD: assert property ($fell(O_SDA_OE_N) |-> in_ack ##1 (!O_SDA_OE_N || scl_fall || start_det || stop_det)) // RULE11
    else $error("acknowledge dropped early");
  AST_FOREIGN_NACK: assert property (byte_done && state == VAB_ST_ADDR && !addr_match |=> O_SDA_OE_N && state == VAB_ST_IGNORE) // RULE11
    else $error("foreign address acknowledged");
  AST_WRAP: assert property (wr_en && sub_addr == VAB_SUB_BLACK3 |=> sub_addr == VAB_SUB_CTRL) // RULE12
    else $error("pointer did not wrap");
  AST_HIGH_SUB: assert property (data_byte && sub_addr > VAB_SUB_TEST && !stop_det // RULE13
    |=> !O_SDA_OE_N && $stable(sub_addr) && $stable(regs_flat))
    else $error("high subaddress not ignored with acknowledge");
  AST_WRITE_ONLY_ON_BYTE: assert property (!wr_en |=> $stable(regs_flat)) // RULE14
    else $error("register changed outside a completed byte");

  // Control byte lands on the four mode outputs
  AST_CTRL_FIELDS: assert property (wr_en && wr_idx == 4'h0 |=> // RULE1
    {O_FEEDBACK_POLARITY_SEL, O_VIDEO_DISABLE, O_OVERLAY_DISABLE, O_PEDESTAL_BLANK_EN} == $past(shift_reg[3:0]))
    else $error("control outputs do not follow written byte");

  // Level registers take their low bits whole
  AST_BRIGHT_WRITE: assert property (wr_en && wr_idx == 4'h1 |=> // RULE3
    O_BRIGHTNESS_LEVEL == $past(shift_reg[5:0]))
    else $error("brightness level wrong after write");
  AST_CONTRAST_WRITE: assert property (wr_en && wr_idx == 4'h2 |=> // RULE3
    O_CONTRAST_LEVEL == $past(shift_reg[5:0]))
    else $error("contrast level wrong after write");
  AST_OVLCON_WRITE: assert property (wr_en && wr_idx == 4'h3 |=> // RULE3
    O_OVERLAY_CONTRAST_LEVEL == $past(shift_reg[3:0]))
    else $error("overlay contrast level wrong after write");

  // Black references keep the full byte
  AST_BLACK1_WRITE: assert property (wr_en && wr_idx == 4'h7 |=> // RULE5
    O_BLACK_REF_CH1 == $past(shift_reg))
    else $error("black reference one not full byte");
  AST_BLACK2_WRITE: assert property (wr_en && wr_idx == 4'h8 |=> // RULE5
    O_BLACK_REF_CH2 == $past(shift_reg))
    else $error("black reference two not full byte");

  // Pointer steps by one inside the bank
  AST_INCREMENT: assert property (wr_en && sub_addr < VAB_SUB_BLACK3 |=> // RULE12
    sub_addr == 8'($past(sub_addr) + 8'h01))
    else $error("pointer did not advance");

  // No acknowledge while idle or ignoring a foreign transfer
  AST_QUIET_SLAVE: assert property ((state == VAB_ST_IDLE || state == VAB_ST_IGNORE) |-> O_SDA_OE_N) // RULE11
    else $error("data line pulled outside an addressed transfer");

  // Stop discards a partial byte and returns to idle
  AST_STOP_DISCARD: assert property (stop_det |=> $stable(regs_flat) && state == VAB_ST_IDLE) // RULE14
    else $error("stop disturbed the bank");
  // Bit counter never runs past one byte
  AST_BIT_CNT_RANGE: assert property (bit_cnt <= VAB_BYTE_BITS) // RULE14
    else $error("bit counter overran a byte");
endmodule : vab_video_adjust_bank

/* File: shared/vab_pkg.sv */
// Constants for the video adjust register bank
package vab_pkg;
  // Two-wire slave address and direction bit
  localparam logic [6:0] VAB_SLAVE_ADDR  = 7'h44;
  localparam logic       VAB_DIR_WRITE   = 1'b0;
  // Subaddress map
  localparam logic [7:0] VAB_SUB_CTRL    = 8'h00;
  localparam logic [7:0] VAB_SUB_BRIGHT  = 8'h01;
  localparam logic [7:0] VAB_SUB_CONTR   = 8'h02;
  localparam logic [7:0] VAB_SUB_OVLCON  = 8'h03;
  localparam logic [7:0] VAB_SUB_GAIN1   = 8'h04;
  localparam logic [7:0] VAB_SUB_GAIN2   = 8'h05;
  localparam logic [7:0] VAB_SUB_GAIN3   = 8'h06;
  localparam logic [7:0] VAB_SUB_BLACK1  = 8'h07;
  localparam logic [7:0] VAB_SUB_BLACK2  = 8'h08;
  localparam logic [7:0] VAB_SUB_BLACK3  = 8'h09;
  localparam logic [7:0] VAB_SUB_UNUSED0 = 8'h0a;
  localparam logic [7:0] VAB_SUB_UNUSED1 = 8'h0e;
  localparam logic [7:0] VAB_SUB_TEST    = 8'h0f;
  localparam int         VAB_NUM_REGS    = 10;
  // Control register field positions
  localparam int         VAB_PED_BIT     = 0;
  localparam int         VAB_OVL_BIT     = 1;
  localparam int         VAB_VID_BIT     = 2;
  localparam int         VAB_FEEDBACK_POLARITY_SEL_BIT    = 3;
  // Field widths
  localparam int         VAB_LEVEL_W     = 6;
  localparam int         VAB_OVLCON_W    = 4;
  localparam int         VAB_REF_W       = 8;
  // Reset value and bit count per byte
  localparam logic [7:0] VAB_RESET_VAL   = 8'h00;
  localparam logic [3:0] VAB_BYTE_BITS   = 4'h8;
  // Kept bits of each register, don't-care bits stored as zero
  localparam logic [7:0] VAB_WMASK [0:9] = '{8'h0f, 8'h3f, 8'h3f, 8'h0f, 8'h3f,
                                             8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff};
  // Receiver states
  typedef enum logic [2:0] {VAB_ST_IDLE, VAB_ST_ADDR, VAB_ST_SUB, VAB_ST_DATA, VAB_ST_IGNORE} vab_state_t;
endpackage : vab_pkg

/* File: verif/vab_master_model.sv */
// Two-wire bus master model driving the bank's slave port
`timescale 1ns/100ps
module vab_master_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // One bus step after a clock edge, then hold
  task automatic set(input logic scl, input logic sda, input int n);
    @(posedge i_clk);
    o_scl <= scl;
    o_sda <= sda;
    repeat (n - 1) @(posedge i_clk);
  endtask : set
  // Start, also a repeated one; data falls with clock high
  task automatic start();
    set(o_scl, 1'b1, 2);
    set(1'b1, 1'b1, 4);
    set(1'b1, 1'b0, 4);
    set(1'b0, 1'b0, 2);
  endtask : start
  // Top bits of a byte, MSB first, data moves only while clock low
  task automatic bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      set(1'b0, b[7-i], 2);
      set(1'b1, b[7-i], 4);
      set(1'b0, b[7-i], 2);
    end
  endtask : bits
  // Whole byte, then release data and sample the acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    bits(b, 8);
    set(1'b0, 1'b1, 2);
    set(1'b1, 1'b1, 2);
    ack = i_sda;
    set(1'b1, 1'b1, 2);
    set(1'b0, 1'b1, 2);
  endtask : send
  // Stop, data rises with clock high
  task automatic stop();
    set(1'b0, 1'b0, 2);
    set(1'b1, 1'b0, 4);
    set(1'b1, 1'b1, 4);
  endtask : stop
endmodule : vab_master_model

/* File: verif/tb.sv */
// Self-checking bench for the video adjust register bank
`timescale 1ns/100ps
module tb;
  import vab_pkg::*;
  logic        I_CLK = 1'b0;
  logic        I_NRST = 1'b0;
  wire  logic  I_SCL;
  wire  logic  I_SDA;
  wire  logic  m_sda;
  wire  logic  O_SDA, O_SDA_OE_N, O_FEEDBACK_POLARITY_SEL, O_VIDEO_DISABLE, O_OVERLAY_DISABLE, O_PEDESTAL_BLANK_EN;
  wire  logic [5:0] O_BRIGHTNESS_LEVEL, O_CONTRAST_LEVEL, O_GAIN_CH1, O_GAIN_CH2, O_GAIN_CH3;
  wire  logic [3:0] O_OVERLAY_CONTRAST_LEVEL;
  wire  logic [7:0] O_BLACK_REF_CH1, O_BLACK_REF_CH2, O_BLACK_REF_CH3, O_PRODUCTION_TEST;
  logic [7:0]  shadow [0:9];
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;
  bit          tidy = 1'b1;
  // Wired-AND data line with pull-up
  assign I_SDA = m_sda & (O_SDA_OE_N | O_SDA);
  wire logic [69:0] obs = {O_FEEDBACK_POLARITY_SEL, O_VIDEO_DISABLE, O_OVERLAY_DISABLE, O_PEDESTAL_BLANK_EN,
    O_BRIGHTNESS_LEVEL, O_CONTRAST_LEVEL, O_OVERLAY_CONTRAST_LEVEL, O_GAIN_CH1, O_GAIN_CH2, O_GAIN_CH3,
    O_BLACK_REF_CH1, O_BLACK_REF_CH2, O_BLACK_REF_CH3, O_PRODUCTION_TEST};
  always #2 I_CLK = ~I_CLK;
  vab_master_model m (.i_clk(I_CLK), .i_sda(I_SDA), .o_scl(I_SCL), .o_sda(m_sda));
  vab_video_adjust_bank dut (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA(O_SDA),
    .O_SDA_OE_N(O_SDA_OE_N), .O_FEEDBACK_POLARITY_SEL(O_FEEDBACK_POLARITY_SEL), .O_VIDEO_DISABLE(O_VIDEO_DISABLE),
    .O_OVERLAY_DISABLE(O_OVERLAY_DISABLE), .O_PEDESTAL_BLANK_EN(O_PEDESTAL_BLANK_EN),
    .O_BRIGHTNESS_LEVEL(O_BRIGHTNESS_LEVEL), .O_CONTRAST_LEVEL(O_CONTRAST_LEVEL),
    .O_OVERLAY_CONTRAST_LEVEL(O_OVERLAY_CONTRAST_LEVEL), .O_GAIN_CH1(O_GAIN_CH1), .O_GAIN_CH2(O_GAIN_CH2),
    .O_GAIN_CH3(O_GAIN_CH3), .O_BLACK_REF_CH1(O_BLACK_REF_CH1), .O_BLACK_REF_CH2(O_BLACK_REF_CH2),
    .O_BLACK_REF_CH3(O_BLACK_REF_CH3), .O_PRODUCTION_TEST(O_PRODUCTION_TEST));
  // Expected settings, test byte never written
  function automatic logic [69:0] exp_vec();
    return {shadow[0][3:0], shadow[1][5:0], shadow[2][5:0], shadow[3][3:0], shadow[4][5:0], shadow[5][5:0],
            shadow[6][5:0], shadow[7], shadow[8], shadow[9], VAB_RESET_VAL};
  endfunction : exp_vec
  task automatic check(input logic [69:0] seen, input logic [69:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // One write transfer of n random bytes, shadow follows the pointer
  task automatic wr(input logic [7:0] adr, input logic [7:0] sub, input int n);
    logic       ack;
    logic       ok;
    logic [7:0] p;
    logic [7:0] d;
    ok = (adr === {VAB_SLAVE_ADDR, VAB_DIR_WRITE});
    p = sub;
    m.start();
    m.send(adr, ack);
    check({69'h0, ack}, {69'h0, ~ok});
    m.send(sub, ack);
    check({69'h0, ack}, {69'h0, ~ok});
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      if (tidy && p <= VAB_SUB_BLACK3) d = d & VAB_WMASK[p];
      m.send(d, ack);
      check({69'h0, ack}, {69'h0, ~ok});
      if (ok && p <= VAB_SUB_BLACK3) begin
        shadow[p] = d & VAB_WMASK[p];
        p = (p == VAB_SUB_BLACK3) ? VAB_SUB_CTRL : p + 8'h01;
      end
    end
    m.stop();
    check(obs, exp_vec());
  endtask : wr
  // Cycle ceiling against hangs
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    logic ack;
    foreach (shadow[i]) shadow[i] = VAB_RESET_VAL;
    void'($urandom(32'h1d05));
    repeat (5) @(posedge I_CLK);
    I_NRST <= 1'b1;
    repeat (3) @(posedge I_CLK);
    check(obs, exp_vec());
    wr(8'h88, VAB_SUB_CTRL, 12);
    tidy = 1'b0;
    // Random bursts, subaddress kept off the test byte
    for (int k = 0; k < 10; k++) wr(8'h88, 8'($urandom_range(9, 0)), $urandom_range(4, 1));
    wr(8'h88, VAB_SUB_UNUSED0, 2);
    wr(8'h88, VAB_SUB_UNUSED1, 1);
    wr(8'h88, 8'($urandom_range(255, 16)), 2);
    wr(8'h89, VAB_SUB_BRIGHT, 1);
    wr(8'h8a, VAB_SUB_BRIGHT, 1);
    // Stop in mid-byte leaves the setting untouched
    m.start();
    m.send(8'h88, ack);
    m.send(VAB_SUB_CONTR, ack);
    m.bits(8'h3f, 4);
    m.stop();
    check(obs, exp_vec());
    // Reset in mid-run clears everything
    @(posedge I_CLK);
    I_NRST <= 1'b0;
    repeat (3) @(posedge I_CLK);
    I_NRST <= 1'b1;
    foreach (shadow[i]) shadow[i] = VAB_RESET_VAL;
    repeat (2) @(posedge I_CLK);
    check(obs, exp_vec());
    wr(8'h88, VAB_SUB_BLACK1, 3);
    give_verdict();
  end
endmodule : tb
